// ---- bbd_defines.vh ----
/*
 * Opcodes, stretching special registers and reset values.
 * Assumes inclusion by bare name.
 */
`ifndef BBD_DEFINES_VH
`define BBD_DEFINES_VH

// ************************************************************
// Opcodes
// ************************************************************
`define BBD_OP_OR_NBIT    8'ha0
`define BBD_OP_MOV_C_BIT  8'ha2
`define BBD_OP_MOV_BIT_C  8'h92
`define BBD_OP_FAR_CALL   8'h12
`define BBD_OP_SUB_EXIT   8'h22
`define BBD_OP_ISR_EXIT   8'h32
`define BBD_OP_FAR_JUMP   8'h02
`define BBD_OP_REL_JUMP   8'h80
`define BBD_OP_IND_JUMP   8'h73
`define BBD_OP_ACC_ZERO   8'h60
`define BBD_OP_ACC_NZERO  8'h70
`define BBD_OP_CY_SET     8'h40
`define BBD_OP_CY_CLR     8'h50
`define BBD_OP_BIT_SET    8'h20
`define BBD_OP_BIT_CLR    8'h30
`define BBD_OP_BIT_CLEAR  8'h10
`define BBD_OP_CMP_DIR    8'hb5
`define BBD_OP_CMP_IMM    8'hb4
`define BBD_OP_DEC_DIR    8'hd5
`define BBD_PG_CALL_LOW   5'h11
`define BBD_PG_JUMP_LOW   5'h01
`define BBD_CMP_REG_HI    5'h17
`define BBD_CMP_IND_HI    7'h5b
`define BBD_DEC_REG_HI    5'h1b

// ************************************************************
// Special registers costing one more cycle
// ************************************************************
`define BBD_SFR_FLAGS     8'hd0
`define BBD_SFR_SP        8'h81
`define BBD_SFR_PSEL      8'h86
`define BBD_SFR_IE        8'ha8
`define BBD_SFR_EIE       8'he8
`define BBD_SFR_IPL       8'ha9
`define BBD_SFR_IPH       8'hb8
`define BBD_SFR_EIPL      8'hf8
`define BBD_SFR_EIPH      8'hf9

// ************************************************************
// Reset values and bit addressing
// ************************************************************
`define BBD_PC_RST        16'h0000
`define BBD_SP_RST        8'h07
`define BBD_BIT_RAM_BASE  4'h2

`endif

// ---- bbd_core.v ----
/*
 * Execute unit for boolean-carry moves and program branching.
 * Assumes memories and bit space answer within the address cycle.
 */
// Contract
// - A0 ors carry with inverted bit, two bytes, two cycles.
// - Short page call: two cycles, push low then high, pre-increment, load page.
// - Far call 12: three cycles, push low then high, load 16-bit target.
// - Exits 22 and 32: three cycles, pop high then low, post-decrement.
// - Page jump: two cycles, replace program_counter bits 10..0 only.
// - Far jump 02: three bytes, three cycles, load 16-bit address.
// - Relative jump 80: two bytes, three cycles, always adds offset.
// - Indirect jump 73: one byte, three cycles, accumulator plus data_pointer.
// - Opcode 60 branches when accumulator is zero, three cycles.
// - Opcode 70 branches when accumulator is nonzero, three cycles.
// - Opcodes 40 and 50 branch on carry set or clear, three cycles.
// - Opcodes 20 and 30 branch on bit one or zero, four cycles.
// - Opcode 10 clears the bit and branches when the bit is one.
// - Taken bit-and-clear branch spends one extra cycle for the clear.
// - B5 compares accumulator with direct byte, five cycles, carry by order.
// - B8..BF compare work_reg with immediate, four cycles.
// - B6..B7 compare indirect byte with immediate, five cycles.
// - D8..DF decrement work_reg, branch when nonzero, four cycles.
// - D5 decrements direct byte, branches when nonzero, five cycles.
// - Direct writes by D5 and taken 10 to marked special registers take one extra cycle; B5 reads do not.
`timescale 1ns/10ps
`include "bbd_defines.vh"

module bbd_core
(
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        nrst_i,
   // Program memory
   output wire [15:0] code_addr_o,
   input  wire [7:0]  code_data_i,
   // Data RAM, stack and direct space
   output reg  [7:0]  ram_addr_o,
   output reg  [7:0]  ram_wdata_o,
   output reg         ram_we_o,
   input  wire [7:0]  ram_rdata_i,
   // Bit space
   output reg  [7:0]  bit_addr_o,
   output reg         bit_wdata_o,
   output reg         bit_we_o,
   input  wire        bit_rdata_i,
   // Core state from outside
   input  wire [7:0]  acc_i,
   input  wire [15:0] data_pointer_i,
   input  wire [1:0]  bank_i,
   // Status
   output wire [7:0]  sp_o,
   output wire        carry_o,
   output wire        insn_start_o,
   output reg         irq_exit_o,
   output reg         unknown_op_o
);

   // ************************************************************
   // State
   // ************************************************************
   reg [15:0] pc_r, pc_nxt;
   reg [7:0]  sp_r, sp_nxt;
   reg        cy_r, cy_nxt;
   reg [2:0]  cyc_r, cyc_nxt;
   reg [7:0]  op_r, b2_r, b2_nxt, b3_r, b3_nxt, tmp_r, tmp_nxt;
   reg        wt_r, wt_nxt;
   reg        cmp_go;
   reg [7:0]  cmp_a, cmp_d;
   reg        spc;

   // Opcode and operands are taken straight off the bus in their own cycle
   wire [7:0]  op    = (cyc_r == 3'h0) ? code_data_i : op_r;
   wire [7:0]  opnd2 = (cyc_r == 3'h1) ? code_data_i : b2_r;
   wire [7:0]  opnd3 = (cyc_r == 3'h2) ? code_data_i : b3_r;
   wire [15:0] pc_inc = pc_r + 16'h0001;
   wire [15:0] pc_two = pc_r + 16'h0002;
   wire [1:0]  len   = insn_len(op);
   wire [15:0] pcb   = ({1'b0, cyc_r} < {1'b0, len}) ? pc_inc : pc_r;
   wire [7:0]  rel8  = (len == 2'h3) ? opnd3 : opnd2;
   wire [15:0] tgt   = pcb + {{8{rel8[7]}}, rel8};
   wire [7:0]  reg_a = {3'h0, bank_i, op[2:0]};
   wire [7:0]  ind_a = {3'h0, bank_i, 2'h0, op[0]};
   wire [7:0]  bit_byte = b2_r[7] ? {b2_r[7:3], 3'h0} : {`BBD_BIT_RAM_BASE, b2_r[6:3]};
   wire [7:0]  dec_v = tmp_r - 8'h01;

   assign code_addr_o  = pc_r;
   assign sp_o         = sp_r;
   assign carry_o      = cy_r;
   assign insn_start_o = (cyc_r == 3'h0) & ~wt_r;

   // ************************************************************
   // Instruction length in bytes
   // ************************************************************
   function [1:0] insn_len;
      input [7:0] o;
      begin
         insn_len = 2'h1;
         if (o[4:0] == `BBD_PG_CALL_LOW || o[4:0] == `BBD_PG_JUMP_LOW ||
             o == `BBD_OP_OR_NBIT || o == `BBD_OP_MOV_C_BIT || o == `BBD_OP_MOV_BIT_C ||
             o == `BBD_OP_REL_JUMP || o == `BBD_OP_ACC_ZERO || o == `BBD_OP_ACC_NZERO ||
             o == `BBD_OP_CY_SET || o == `BBD_OP_CY_CLR || o[7:3] == `BBD_DEC_REG_HI)
            insn_len = 2'h2;
         if (o == `BBD_OP_FAR_CALL || o == `BBD_OP_FAR_JUMP || o == `BBD_OP_BIT_SET ||
             o == `BBD_OP_BIT_CLR || o == `BBD_OP_BIT_CLEAR || o == `BBD_OP_CMP_DIR ||
             o == `BBD_OP_CMP_IMM || o[7:3] == `BBD_CMP_REG_HI ||
             o[7:1] == `BBD_CMP_IND_HI || o == `BBD_OP_DEC_DIR)
            insn_len = 2'h3;
      end
   endfunction

   // Special registers whose direct write by D5 or taken 10 costs one more cycle
   function is_spc;
      input [7:0] a;
      begin
         is_spc = (a == `BBD_SFR_FLAGS) || (a == `BBD_SFR_SP) || (a == `BBD_SFR_PSEL) ||
                  (a == `BBD_SFR_IE) || (a == `BBD_SFR_EIE) || (a == `BBD_SFR_IPL) ||
                  (a == `BBD_SFR_IPH) || (a == `BBD_SFR_EIPL) || (a == `BBD_SFR_EIPH);
      end
   endfunction

   // ************************************************************
   // Sequencer: one pass per clock, final step returns cyc to 0
   // ************************************************************
   always @*
   begin
      pc_nxt       = ({1'b0, cyc_r} < {1'b0, len}) ? pc_inc : pc_r;
      sp_nxt       = sp_r;
      cy_nxt       = cy_r;
      cyc_nxt      = cyc_r + 3'h1;
      b2_nxt       = opnd2;
      b3_nxt       = opnd3;
      tmp_nxt      = tmp_r;
      wt_nxt       = wt_r;
      ram_addr_o   = 8'h00;
      ram_wdata_o  = 8'h00;
      ram_we_o     = 1'b0;
      bit_addr_o   = opnd2;
      bit_wdata_o  = 1'b0;
      bit_we_o     = 1'b0;
      irq_exit_o   = 1'b0;
      unknown_op_o = 1'b0;
      cmp_go       = 1'b0;
      cmp_a        = acc_i;
      cmp_d        = b2_r;
      spc          = 1'b0;
      if (op[4:0] == `BBD_PG_CALL_LOW)
      begin
         // Return address pushed low byte first, high byte in the last cycle
         ram_addr_o = sp_r + 8'h01;
         ram_we_o   = 1'b1;
         sp_nxt     = sp_r + 8'h01;
         if (cyc_r == 3'h0)
            ram_wdata_o = pc_two[7:0];
         else
         begin
            ram_wdata_o = pcb[15:8];
            pc_nxt      = {pcb[15:11], op[7:5], opnd2};
            cyc_nxt     = 3'h0;
         end
      end
      else if (op[4:0] == `BBD_PG_JUMP_LOW)
      begin
         if (cyc_r == 3'h1)
         begin
            pc_nxt  = {pcb[15:11], op[7:5], opnd2};
            cyc_nxt = 3'h0;
         end
      end
      else
      begin
         case (op)
            `BBD_OP_OR_NBIT, `BBD_OP_MOV_C_BIT, `BBD_OP_MOV_BIT_C:
               if (cyc_r == 3'h1)
               begin
                  cyc_nxt = 3'h0;
                  if (op == `BBD_OP_OR_NBIT)
                     cy_nxt = cy_r | ~bit_rdata_i;
                  else if (op == `BBD_OP_MOV_C_BIT)
                     cy_nxt = bit_rdata_i;
                  else
                  begin
                     bit_we_o    = 1'b1;
                     bit_wdata_o = cy_r;
                  end
               end
            `BBD_OP_FAR_CALL:
               if (cyc_r != 3'h0)
               begin
                  ram_addr_o = sp_r + 8'h01;
                  ram_we_o   = 1'b1;
                  sp_nxt     = sp_r + 8'h01;
                  if (cyc_r == 3'h1)
                     ram_wdata_o = pc_two[7:0];
                  else
                  begin
                     ram_wdata_o = pcb[15:8];
                     pc_nxt      = {b2_r, opnd3};
                     cyc_nxt     = 3'h0;
                  end
               end
            `BBD_OP_SUB_EXIT, `BBD_OP_ISR_EXIT:
               if (cyc_r != 3'h0)
               begin
                  // High byte pops first, pointer drops after each read
                  ram_addr_o = sp_r;
                  sp_nxt     = sp_r - 8'h01;
                  if (cyc_r == 3'h1)
                     tmp_nxt = ram_rdata_i;
                  else
                  begin
                     pc_nxt     = {tmp_r, ram_rdata_i};
                     irq_exit_o = (op == `BBD_OP_ISR_EXIT);
                     cyc_nxt    = 3'h0;
                  end
               end
            `BBD_OP_FAR_JUMP:
               if (cyc_r == 3'h2)
               begin
                  pc_nxt  = {b2_r, opnd3};
                  cyc_nxt = 3'h0;
               end
            `BBD_OP_IND_JUMP:
               if (cyc_r == 3'h2)
               begin
                  pc_nxt  = {8'h00, acc_i} + data_pointer_i;
                  cyc_nxt = 3'h0;
               end
            `BBD_OP_REL_JUMP, `BBD_OP_ACC_ZERO, `BBD_OP_ACC_NZERO,
            `BBD_OP_CY_SET, `BBD_OP_CY_CLR:
               if (cyc_r == 3'h2)
               begin
                  cyc_nxt = 3'h0;
                  if ((op == `BBD_OP_REL_JUMP) ||
                      (op == `BBD_OP_ACC_ZERO && acc_i == 8'h00) ||
                      (op == `BBD_OP_ACC_NZERO && acc_i != 8'h00) ||
                      (op == `BBD_OP_CY_SET && cy_r) ||
                      (op == `BBD_OP_CY_CLR && !cy_r))
                     pc_nxt = tgt;
               end
            `BBD_OP_BIT_SET, `BBD_OP_BIT_CLR:
               if (cyc_r == 3'h3)
               begin
                  bit_addr_o = b2_r;
                  cyc_nxt    = 3'h0;
                  if (bit_rdata_i == (op == `BBD_OP_BIT_SET))
                     pc_nxt = tgt;
               end
            `BBD_OP_BIT_CLEAR:
               if (cyc_r >= 3'h3)
               begin
                  bit_addr_o = b2_r;
                  spc        = is_spc(bit_byte);
                  if (cyc_r == 3'h3)
                  begin
                     // Not taken ends here; taken goes on to clear
                     if (!bit_rdata_i)
                        cyc_nxt = 3'h0;
                  end
                  else if (spc && !wt_r)
                  begin
                     wt_nxt  = 1'b1;
                     cyc_nxt = cyc_r;
                  end
                  else
                  begin
                     bit_we_o = 1'b1;
                     pc_nxt   = tgt;
                     wt_nxt   = 1'b0;
                     cyc_nxt  = 3'h0;
                  end
               end
            `BBD_OP_CMP_DIR:
               if (cyc_r == 3'h3)
               begin
                  ram_addr_o = b2_r;
                  tmp_nxt    = ram_rdata_i;
               end
               else if (cyc_r == 3'h4)
               begin
                  cmp_go  = 1'b1;
                  cmp_d   = tmp_r;
                  cyc_nxt = 3'h0;
               end
            `BBD_OP_CMP_IMM:
               if (cyc_r == 3'h3)
               begin
                  cmp_go  = 1'b1;
                  cyc_nxt = 3'h0;
               end
            `BBD_OP_DEC_DIR:
               if (cyc_r == 3'h3)
               begin
                  ram_addr_o = b2_r;
                  tmp_nxt    = ram_rdata_i;
               end
               else if (cyc_r == 3'h4)
               begin
                  spc = is_spc(b2_r);
                  if (spc && !wt_r)
                  begin
                     wt_nxt  = 1'b1;
                     cyc_nxt = cyc_r;
                  end
                  else
                  begin
                     ram_addr_o  = b2_r;
                     ram_wdata_o = dec_v;
                     ram_we_o    = 1'b1;
                     wt_nxt      = 1'b0;
                     cyc_nxt     = 3'h0;
                     if (dec_v != 8'h00)
                        pc_nxt = tgt;
                  end
               end
            default:
               if (op[7:3] == `BBD_CMP_REG_HI)
               begin
                  if (cyc_r == 3'h3)
                  begin
                     ram_addr_o = reg_a;
                     cmp_a      = ram_rdata_i;
                     cmp_go     = 1'b1;
                     cyc_nxt    = 3'h0;
                  end
               end
               else if (op[7:1] == `BBD_CMP_IND_HI)
               begin
                  // Pointer first, then the byte it selects
                  if (cyc_r == 3'h3)
                  begin
                     ram_addr_o = ind_a;
                     tmp_nxt    = ram_rdata_i;
                  end
                  else if (cyc_r == 3'h4)
                  begin
                     ram_addr_o = tmp_r;
                     cmp_a      = ram_rdata_i;
                     cmp_go     = 1'b1;
                     cyc_nxt    = 3'h0;
                  end
               end
               else if (op[7:3] == `BBD_DEC_REG_HI)
               begin
                  if (cyc_r == 3'h2)
                  begin
                     ram_addr_o = reg_a;
                     tmp_nxt    = ram_rdata_i;
                  end
                  else if (cyc_r == 3'h3)
                  begin
                     ram_addr_o  = reg_a;
                     ram_wdata_o = dec_v;
                     ram_we_o    = 1'b1;
                     cyc_nxt     = 3'h0;
                     if (dec_v != 8'h00)
                        pc_nxt = tgt;
                  end
               end
               else
               begin
                  // Outside this group: skip in one cycle and flag it
                  unknown_op_o = 1'b1;
                  cyc_nxt      = 3'h0;
               end
         endcase
      end
      // Shared compare: branch on inequality, carry when data is larger
      if (cmp_go && (cmp_a != cmp_d))
      begin
         pc_nxt = tgt;
         cy_nxt = (cmp_d > cmp_a);
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pc_r  <= `BBD_PC_RST;
         sp_r  <= `BBD_SP_RST;
         cy_r  <= 1'b0;
         cyc_r <= 3'h0;
         op_r  <= 8'h00;
         b2_r  <= 8'h00;
         b3_r  <= 8'h00;
         tmp_r <= 8'h00;
         wt_r  <= 1'b0;
      end
      else
      begin
         pc_r  <= pc_nxt;
         sp_r  <= sp_nxt;
         cy_r  <= cy_nxt;
         cyc_r <= cyc_nxt;
         op_r  <= op;
         b2_r  <= b2_nxt;
         b3_r  <= b3_nxt;
         tmp_r <= tmp_nxt;
         wt_r  <= wt_nxt;
      end
   end

endmodule // bbd_core

// ---- bbd_core_properties.sv ----
/*
 * Port-level checks for the branch execute unit.
 * Assumes one clock and an async active-low reset.
 */
`timescale 1ns/10ps
module bbd_core_checker
(
   // Clock and reset
   input logic        sys_clk_i,
   input logic        nrst_i,
   // Memory side
   input logic [15:0] code_addr_o,
   input logic [7:0]  code_data_i,
   input logic [7:0]  ram_addr_o,
   input logic [7:0]  ram_wdata_o,
   input logic        ram_we_o,
   input logic        bit_wdata_o,
   input logic        bit_we_o,
   input logic        bit_rdata_i,
   // Core state and status
   input logic [7:0]  acc_i,
   input logic [15:0] data_pointer_i,
   input logic [7:0]  sp_o,
   input logic        carry_o,
   input logic        insn_start_o,
   input logic        irq_exit_o
);
   // ************************************************************
   // Opcode seen in a fetch cycle only
   // ************************************************************
   wire [7:0] op = insn_start_o ? code_data_i : 8'h00;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   bool_or_a: assert property (op == 8'ha0 |-> ##2 insn_start_o &&
      carry_o == ($past(carry_o, 2) | ~$past(bit_rdata_i))) else $error("or-not-bit");
   bit_store_a: assert property (op == 8'h92 |=> bit_we_o && bit_wdata_o == carry_o
      ##1 insn_start_o) else $error("bit store");
   page_call_a: assert property (op[4:0] == 5'h11 |-> ##2 insn_start_o &&
      sp_o == $past(sp_o, 2) + 8'h02 &&
      code_addr_o[10:0] == {$past(code_data_i[7:5], 2), $past(code_data_i)})
      else $error("page call");
   call_push_a: assert property (op == 8'h12 |=> ram_we_o &&
      ram_addr_o == $past(sp_o) + 8'h01 && ram_wdata_o == $past(code_addr_o[7:0]) + 8'h03
      ##1 ram_we_o && ram_addr_o == $past(sp_o, 2) + 8'h02 ##1 insn_start_o)
      else $error("far call");
   exit_pop_a: assert property (op == 8'h22 || op == 8'h32 |=> !insn_start_o
      ##1 !insn_start_o ##1 insn_start_o && sp_o == $past(sp_o, 3) - 8'h02)
      else $error("exit pop");
   irq_exit_a: assert property (op == 8'h32 |-> !irq_exit_o ##1 !irq_exit_o
      ##1 irq_exit_o) else $error("isr exit");
   page_jump_a: assert property (op[4:0] == 5'h01 |-> ##2 insn_start_o &&
      code_addr_o[10:0] == {$past(code_data_i[7:5], 2), $past(code_data_i)})
      else $error("page jump");
   far_jump_a: assert property (op == 8'h02 |-> ##3 insn_start_o &&
      code_addr_o == {$past(code_data_i, 2), $past(code_data_i)}) else $error("far jump");
   rel_jump_a: assert property (op == 8'h80 |-> ##3 insn_start_o &&
      code_addr_o == $past(code_addr_o, 3) + 16'h0002 +
      {{8{$past(code_data_i[7], 2)}}, $past(code_data_i, 2)}) else $error("rel jump");
   ind_jump_a: assert property (op == 8'h73 |-> ##3 insn_start_o &&
      code_addr_o == {8'h00, $past(acc_i, 3)} + $past(data_pointer_i, 3)) else $error("ind jump");
   bit_branch_a: assert property (op == 8'h20 || op == 8'h30 |=>
      !insn_start_o [*3] ##1 insn_start_o) else $error("bit branch");
   clear_taken_a: assert property (op == 8'h10 |-> ##3 (if (bit_rdata_i)
      (##1 bit_we_o && !bit_wdata_o && !insn_start_o) else (##1 insn_start_o)))
      else $error("bit clear");
   imm_compare_a: assert property (op == 8'hb4 |-> ##4 insn_start_o && carry_o ==
      (($past(code_data_i, 3) == $past(acc_i, 4)) ? $past(carry_o, 4) :
      ($past(code_data_i, 3) > $past(acc_i, 4)))) else $error("imm compare");
endmodule // bbd_core_checker

bind bbd_core bbd_core_checker u_bbd_core_checker (.*);

// ---- bbd_mem.sv ----
/*
 * Code, data RAM and bit space model.
 * Reads answer in-cycle, writes land on the edge.
 */
`timescale 1ns/10ps
module bbd_mem
(
   // Clock
   input  logic        sys_clk_i,
   // Program memory
   input  logic [15:0] code_addr_i,
   output logic [7:0]  code_data_o,
   // Data RAM and direct space
   input  logic [7:0]  ram_addr_i,
   input  logic [7:0]  ram_wdata_i,
   input  logic        ram_we_i,
   output logic [7:0]  ram_rdata_o,
   // Bit space
   input  logic [7:0]  bit_addr_i,
   input  logic        bit_wdata_i,
   input  logic        bit_we_i,
   output logic        bit_rdata_o
);
   logic [7:0] code [0:65535];
   logic [7:0] ram  [0:255];
   // Bits below 80 in bytes 20..2f
   wire  [7:0] bit_byte = bit_addr_i[7] ? (bit_addr_i & 8'hf8) : {4'h2, bit_addr_i[6:3]};

   // Reads answer in-cycle; direct space is modelled as plain RAM
   assign code_data_o = code[code_addr_i];
   assign ram_rdata_o = ram[ram_addr_i];
   assign bit_rdata_o = ram[bit_byte][bit_addr_i[2:0]];

   // Writes land on the rising edge
   always @(posedge sys_clk_i)
   begin
      if (ram_we_i)
         ram[ram_addr_i] <= ram_wdata_i;
      if (bit_we_i)
         ram[bit_byte][bit_addr_i[2:0]] <= bit_wdata_i;
   end
endmodule // bbd_mem

// ---- branch_bool_decoder_bench.sv ----
/*
 * Bench: reference pc checked per instruction, stack and carry after selected ones.
 * Assumes fetch starts at 0000 after reset.
 */
`timescale 1ns/10ps
module branch_bool_decoder_bench;
   logic        sys_clk_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic [7:0]  acc_i     = 8'h00;
   logic [15:0] data_pointer_i    = 16'h0000;
   logic [1:0]  bank_i    = 2'h1;
   wire  [15:0] code_addr_o;
   wire  [7:0]  code_data_i, ram_addr_o, ram_wdata_o, ram_rdata_i, bit_addr_o, sp_o;
   wire         ram_we_o, bit_wdata_o, bit_we_o, bit_rdata_i, carry_o, insn_start_o;
   wire         irq_exit_o, unknown_op_o;
   integer      miscompares = 0;
   integer      n_compared  = 0;
   integer      i, k;
   logic [15:0] mpc, ret;
   logic [7:0]  msp, v, d, r, op;
   logic        mcy, tk;
   logic [7:0]  ops [0:3] = '{8'h60, 8'h70, 8'h40, 8'h50};
   logic [7:0]  cop [0:3] = '{8'hb4, 8'hb5, 8'hbb, 8'hb7};

   bbd_core u_bbd_core (.*);
   bbd_mem u_bbd_mem (.sys_clk_i, .code_addr_i(code_addr_o), .code_data_o(code_data_i),
      .ram_addr_i(ram_addr_o), .ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o),
      .ram_rdata_o(ram_rdata_i), .bit_addr_i(bit_addr_o), .bit_wdata_i(bit_wdata_o),
      .bit_we_i(bit_we_o), .bit_rdata_o(bit_rdata_i));

   // ************************************************************
   // Helpers
   // ************************************************************
   always #5 sys_clk_i = ~sys_clk_i;

   function automatic logic [15:0] rl(input logic [15:0] p, input logic [7:0] o);
      return p + {{8{o[7]}}, o};
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Place one instruction, count its cycles, check next pc
   task automatic exec(input logic [7:0] o, b2, b3, input integer cyc, input logic [15:0] npc);
      integer n;
      u_bbd_mem.code[mpc] = o;
      u_bbd_mem.code[mpc + 16'h1] = b2;
      u_bbd_mem.code[mpc + 16'h2] = b3;
      n = 0;
      do
      begin
         @(negedge sys_clk_i);
         n = n + 1;
      end
      while (insn_start_o !== 1'b1 && n < 20);
      check("cycles", 16'(n), 16'(cyc));
      mpc = npc;
      check("pc", code_addr_o, mpc);
   endtask

   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Watchdog: tests need under 1000 cycles
   initial
   begin
      #50000;
      miscompares = miscompares + 1;
      complete_run;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      void'($urandom(82200));
      mpc = 16'h0000;
      msp = 8'h07;
      repeat (3) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      check("reset sp", 16'(sp_o), 16'h0007);
      check("reset carry", 16'(carry_o), 16'h0000);
      // Boolean moves: bit 08 is bit 0 of byte 21
      u_bbd_mem.ram[8'h21] = 8'h00;
      exec(8'ha2, 8'h08, 8'h00, 2, mpc + 16'h2);
      check("carry", 16'(carry_o), 16'h0000);
      u_bbd_mem.ram[8'h21] = 8'h01;
      exec(8'ha0, 8'h08, 8'h00, 2, mpc + 16'h2);
      check("carry", 16'(carry_o), 16'h0000);
      u_bbd_mem.ram[8'h21] = 8'h00;
      exec(8'ha0, 8'h08, 8'h00, 2, mpc + 16'h2);
      check("carry", 16'(carry_o), 16'h0001);
      exec(8'h92, 8'h09, 8'h00, 2, mpc + 16'h2);
      check("bit store", 16'(u_bbd_mem.ram[8'h21]), 16'h0002);
      $display("Test boolean done");
      // Calls and exits, stack low byte first
      ret = mpc + 16'h3;
      exec(8'h12, 8'h12, 8'h34, 3, 16'h1234);
      check("sp", 16'(sp_o), 16'(msp + 8'h2));
      check("push low", 16'(u_bbd_mem.ram[msp + 8'h1]), 16'(ret[7:0]));
      check("push high", 16'(u_bbd_mem.ram[msp + 8'h2]), 16'(ret[15:8]));
      exec(8'hb1, 8'h56, 8'h00, 2, {mpc[15:11] + 5'h0, 3'h5, 8'h56});
      check("push low", 16'(u_bbd_mem.ram[msp + 8'h3]), 16'h0036);
      check("push high", 16'(u_bbd_mem.ram[msp + 8'h4]), 16'h0012);
      exec(8'h32, 8'h00, 8'h00, 3, 16'h1236);
      check("sp", 16'(sp_o), 16'(msp + 8'h2));
      exec(8'h22, 8'h00, 8'h00, 3, ret);
      check("sp", 16'(sp_o), 16'(msp));
      $display("Test call done");
      // Unconditional jumps, relative offset backwards
      exec(8'h61, 8'h9a, 8'h00, 2, {ret[15:11], 3'h3, 8'h9a});
      exec(8'h02, 8'h40, 8'h00, 3, 16'h4000);
      exec(8'h80, 8'hf0, 8'h00, 3, 16'h3ff2);
      acc_i = 8'($urandom);
      data_pointer_i = 16'h5000;
      exec(8'h73, 8'h00, 8'h00, 3, 16'h5000 + {8'h00, acc_i});
      u_bbd_mem.code[mpc] = 8'h00;
      #1 check("unknown", 16'(unknown_op_o), 16'h0001);
      exec(8'h00, 8'h00, 8'h00, 1, mpc + 16'h1);
      $display("Test jump done");
      // Accumulator and carry branches, each condition both ways
      for (i = 0; i < 8; i++)
      begin
         mcy = i[0];
         acc_i = mcy ? 8'h00 : (8'($urandom) | 8'h01);
         u_bbd_mem.ram[8'h21] = {7'h00, mcy};
         exec(8'ha2, 8'h08, 8'h00, 2, mpc + 16'h2);
         op = ops[i[2:1]];
         r = 8'($urandom);
         tk = (op == 8'h60) ? (acc_i == 8'h00) : (op == 8'h70) ? (acc_i != 8'h00) :
              (op == 8'h40) ? mcy : !mcy;
         exec(op, r, 8'h00, 3, tk ? rl(mpc + 16'h2, r) : mpc + 16'h2);
      end
      // Bit branches, clear only when taken
      for (i = 0; i < 6; i++)
      begin
         op = (i < 2) ? 8'h20 : (i < 4) ? 8'h30 : 8'h10;
         u_bbd_mem.ram[8'h21] = {7'h00, i[0]};
         tk = (op == 8'h30) ? !i[0] : i[0];
         r = 8'($urandom);
         exec(op, 8'h08, r, (op == 8'h10 && tk) ? 5 : 4, tk ? rl(mpc + 16'h3, r) : mpc + 16'h3);
         check("bit", 16'(u_bbd_mem.ram[8'h21]), (op == 8'h10) ? 16'h0000 : 16'(i[0]));
      end
      $display("Test branch done");
      // Compares: equal, data above, data below for every source
      for (i = 0; i < 12; i++)
      begin
         k = i % 3;
         v = 8'($urandom) & 8'h7f | 8'h01;
         d = (k == 0) ? v : (k == 1) ? v + 8'h1 : v - 8'h1;
         acc_i = v;
         u_bbd_mem.ram[8'h30] = d;
         u_bbd_mem.ram[8'h0b] = v;
         u_bbd_mem.ram[8'h09] = 8'h40;
         u_bbd_mem.ram[8'h40] = v;
         op = cop[i / 3];
         r = 8'($urandom);
         mcy = (k == 0) ? carry_o : (k == 1);
         exec(op, (op == 8'hb5) ? 8'h30 : d, r, (op == 8'hb5 || op == 8'hb7) ? 5 : 4,
              (k != 0) ? rl(mpc + 16'h3, r) : mpc + 16'h3);
         if (op == 8'hb5)
            exec(op, 8'h30, r, 5, (k != 0) ? rl(mpc + 16'h3, r) : mpc + 16'h3);
         check("carry", 16'(carry_o), 16'(mcy));
      end
      $display("Test compare done");
      // Decrement loops, special register direct costs one more cycle
      for (i = 0; i < 5; i++)
      begin
         op = (i < 2) ? 8'hdb : 8'hd5;
         v = (i < 2) ? 8'h0b : (i < 4) ? 8'h30 : 8'hd0;
         u_bbd_mem.ram[v] = i[0] ? 8'h01 : 8'h02;
         tk = !i[0];
         r = 8'($urandom);
         exec(op, (i < 2) ? r : v, r, (i < 2) ? 4 : (i < 4) ? 5 : 6,
              tk ? rl(mpc + ((i < 2) ? 16'h2 : 16'h3), r) : mpc + ((i < 2) ? 16'h2 : 16'h3));
         check("decrement", 16'(u_bbd_mem.ram[v]), 16'(!i[0]));
      end
      $display("Test decrement done");
      complete_run;
   end
endmodule // branch_bool_decoder_bench
